// *** design/rbbce_pkg.sv ***
package rbbce_pkg;

  // ***********************************************
  // Widths and address arithmetic
  // ***********************************************
  localparam int PC_W = 22;
  localparam int DW = 16;
  localparam logic [PC_W-1:0] SEQ_STEP = 22'h000001;
  localparam logic [PC_W-1:0] IMM_STEP = 22'h000002;
  localparam logic [PC_W-1:0] BR_BIAS = 22'h000002;
  localparam logic [PC_W-1:0] LINK_BIAS = 22'h000004;

  // ***********************************************
  // Status word bits and fixed registers
  // ***********************************************
  localparam int SR_ZA = 4;
  localparam int SR_ZB = 5;
  localparam int SR_T = 7;
  localparam logic [3:0] INDEX_IDX = 4'h1;
  localparam logic [3:0] LOOP_A_IDX = 4'h6;
  localparam logic [3:0] LOOP_B_IDX = 4'h7;

  // ***********************************************
  // Instruction encodings
  // ***********************************************
  localparam logic [11:0] AND_IMM_TAG = 12'h84f;
  localparam logic [10:0] BIT_MODIFY_TAG = 11'h4f0;
  localparam logic [12:0] STATUS_BIT_CLEAR_TAG = 13'h13d0;
  localparam logic [15:0] BREAK_WORD = 16'h9e99;
  localparam logic [6:0] LOOP_TAG = 7'h63;
  localparam logic [4:0] EXTC_TAG = 5'h18;
  localparam logic [2:0] BR_TAG = 3'h6;
  localparam logic [3:0] CALL_TAG = 4'hb;
  localparam logic [6:0] COPRO_TAG = 7'h70;
  localparam logic [1:0] BIT_RESET_OP = 2'h0;
  localparam logic [1:0] BIT_SET_OP = 2'h1;
  localparam logic [1:0] BIT_FLIP_OP = 2'h2;
  localparam logic [1:0] BIT_TEST_OP = 2'h3;
  localparam logic [1:0] BR_ALWAYS = 2'h1;
  localparam logic [1:0] BR_IF_FALSE = 2'h2;
  localparam logic [1:0] BR_IF_TRUE = 2'h3;

  // ***********************************************
  // Register map (byte offsets)
  // ***********************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SR_OFS = 8'h04;
  localparam logic [7:0] PC_OFS = 8'h08;
  localparam logic [7:0] LINK_OFS = 8'h0c;
  localparam logic [7:0] BASE_OFS = 8'h10;
  localparam logic [7:0] STATE_OFS = 8'h14;
  localparam logic [1:0] GPR_PAGE = 2'h1;
  localparam int CTRL_RUN = 0;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_EXEC = 7'h02,
    ST_IMM = 7'h04,
    ST_MRD = 7'h08,
    ST_MWR = 7'h10,
    ST_COP = 7'h20,
    ST_BRK = 7'h40
  } rbbce_state_t;

  typedef struct packed {
    rbbce_state_t st;
    logic run;
    logic [PC_W-1:0] pc;
    logic [7:0] sr;
    logic [15:0][DW-1:0] gpr;
    logic [PC_W-1:0] base;
    logic [PC_W-1:0] link;
    logic [DW-1:0] instr;
    logic pend;
    logic [PC_W-1:0] pend_pc;
    logic [PC_W-1:0] prog_addr;
    logic [PC_W-1:0] data_addr;
    logic [7:0] data_wdata;
    logic data_we;
    logic [4:0] cop_addr;
    logic cop_stb_n;
    logic cop_wr;
    logic [DW-1:0] cop_wdata;
    logic halt_n;
    logic wb_ack;
    logic [31:0] wb_dat;
  } rbbce_core_t;

endpackage

// *** design/rbbce_exec.sv ***
// Summary of operation
// RULE1 - Large-immediate AND fetches second word, two cycles
// RULE2 - AND result written back, T set when zero
// RULE3 - Loop register destination also updates its zero flag
// RULE4 - Bit op reads byte at base plus index
// RULE5 - Codes reset/set/flip/test; all but test write back
// RULE6 - Loop jump taken when selected zero flag clear
// RULE7 - Loop jump decrements counter, updates zero flag
// RULE8 - Loop jump always has one delay slot
// RULE9 - Software clears zero flag, preloads count minus one
// RULE10 - Branch type: 01 always, 10 false, 11 true
// RULE11 - Branch target PC plus 2 plus signed offset
// RULE12 - Delay bit clear suppresses next instruction when taken
// RULE13 - External condition branch tests selected input
// RULE14 - Break holds PC one cycle, halt low
// RULE15 - Break used only for debugging
// RULE16 - Call saves PC plus 4, jumps relative
// RULE17 - Call always has one delay slot
// RULE18 - Copro transfer drives address, strobe low
// RULE19 - Direction bit picks read into register or write
// RULE20 - Status clear zeroes only the indexed bit
// RULE21 - Immediate word skipped, never decoded
module rbbce_exec #(
  parameter int WB_ADR_W = 8
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [WB_ADR_W-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Program memory
  output logic [rbbce_pkg::PC_W-1:0] O_PROG_ADDR,
  input wire logic [rbbce_pkg::DW-1:0] I_PROG_DATA,
  // Data memory
  output logic [rbbce_pkg::PC_W-1:0] O_DATA_ADDR,
  output logic [7:0] O_DATA_WDATA,
  output logic O_DATA_WE,
  input wire logic [7:0] I_DATA_RDATA,
  // Coprocessor
  output logic [4:0] O_COPRO_REG_ADDR,
  output logic O_COPRO_STROBE_N,
  output logic O_COPRO_WRITE_DIR,
  output logic [rbbce_pkg::DW-1:0] O_COPRO_WDATA,
  input wire logic [rbbce_pkg::DW-1:0] I_COPRO_RDATA,
  input wire logic [3:0] I_EXT_COND,
  // Debug
  output logic O_HALT_INDICATOR_N
);

  generate
    if (WB_ADR_W < 8) begin : g_bad_adr
      $error("WB_ADR_W must be at least 8");
    end
  endgenerate

  rbbce_pkg::rbbce_core_t r_reg;
  rbbce_pkg::rbbce_core_t r_next;

  // ***********************************************
  // Decode of the word on the program bus
  // ***********************************************
  logic [15:0] ins;
  logic in_exec;
  logic is_and_imm;
  logic is_bit_modify;
  logic is_status_bit_clear;
  logic is_break;
  logic is_loop;
  logic is_extc;
  logic is_br;
  logic is_call;
  logic is_copro;
  assign ins = I_PROG_DATA;
  assign in_exec = (r_reg.st == rbbce_pkg::ST_EXEC);
  assign is_and_imm = in_exec && (ins[15:4] == rbbce_pkg::AND_IMM_TAG);
  assign is_bit_modify = in_exec && (ins[15:5] == rbbce_pkg::BIT_MODIFY_TAG);
  assign is_status_bit_clear = in_exec && (ins[15:3] == rbbce_pkg::STATUS_BIT_CLEAR_TAG);
  assign is_break = in_exec && (ins == rbbce_pkg::BREAK_WORD);
  assign is_loop = in_exec && (ins[15:9] == rbbce_pkg::LOOP_TAG) && !ins[7];
  assign is_extc = in_exec && (ins[15:11] == rbbce_pkg::EXTC_TAG) && !ins[9];
  assign is_br = in_exec && (ins[15:13] == rbbce_pkg::BR_TAG) && (ins[12:11] != 2'h0);
  assign is_call = in_exec && (ins[15:12] == rbbce_pkg::CALL_TAG);
  assign is_copro = in_exec && (ins[15:9] == rbbce_pkg::COPRO_TAG);

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // ***********************************************
  // Next state
  // ***********************************************
  always_comb begin
    logic done;
    logic jmp;
    logic slot;
    logic [rbbce_pkg::PC_W-1:0] seq;
    logic [rbbce_pkg::PC_W-1:0] jpc;
    logic [rbbce_pkg::PC_W-1:0] npc;
    logic [15:0] res;
    logic [3:0] lidx;
    logic [7:0] tmp;
    logic [5:0] wadr;
    logic [31:0] wv;
    done = 1'b0;
    jmp = 1'b0;
    slot = 1'b0;
    seq = r_reg.pc + rbbce_pkg::SEQ_STEP;
    jpc = '0;
    npc = '0;
    res = '0;
    lidx = rbbce_pkg::LOOP_A_IDX;
    tmp = '0;
    wadr = I_WB_ADR[7:2];
    wv = '0;
    r_next = r_reg;
    r_next.data_we = 1'b0;
    r_next.cop_stb_n = 1'b1;
    r_next.halt_n = 1'b1;
    r_next.wb_ack = 1'b0;
    unique case (r_reg.st)
      rbbce_pkg::ST_IDLE: begin
        if (r_reg.run) begin
          r_next.prog_addr = r_reg.pc;
          r_next.st = rbbce_pkg::ST_EXEC;
        end
      end
      rbbce_pkg::ST_EXEC: begin
        r_next.instr = ins;
        if (is_and_imm) begin
          r_next.prog_addr = r_reg.pc + rbbce_pkg::SEQ_STEP; // RULE1
          r_next.st = rbbce_pkg::ST_IMM;
        end else if (is_bit_modify) begin
          r_next.data_addr = r_reg.base +
            {6'h00, r_reg.gpr[rbbce_pkg::INDEX_IDX]}; // RULE4
          r_next.st = rbbce_pkg::ST_MRD;
        end else if (is_break) begin
          r_next.halt_n = 1'b0; // RULE14
          r_next.st = rbbce_pkg::ST_BRK;
        end else if (is_status_bit_clear) begin
          r_next.sr[ins[2:0]] = 1'b0; // RULE20
          done = 1'b1;
        end else if (is_copro) begin
          r_next.cop_addr = ins[8:4]; // RULE18
          r_next.cop_stb_n = 1'b0;
          r_next.cop_wr = ins[3]; // RULE19
          r_next.cop_wdata = r_reg.gpr[{1'b0, ins[2:0]}];
          r_next.st = rbbce_pkg::ST_COP;
        end else if (is_call) begin
          r_next.link = r_reg.pc + rbbce_pkg::LINK_BIAS; // RULE16
          jpc = r_reg.pc + rbbce_pkg::BR_BIAS + {{10{ins[11]}}, ins[11:0]};
          jmp = 1'b1;
          slot = 1'b1; // RULE17
          done = 1'b1;
        end else if (is_br) begin
          unique case (ins[12:11]) // RULE10
            rbbce_pkg::BR_ALWAYS: jmp = 1'b1;
            rbbce_pkg::BR_IF_FALSE: jmp = !r_reg.sr[rbbce_pkg::SR_T];
            rbbce_pkg::BR_IF_TRUE: jmp = r_reg.sr[rbbce_pkg::SR_T];
            default: jmp = 1'b0;
          endcase
          jpc = r_reg.pc + rbbce_pkg::BR_BIAS + {{12{ins[9]}}, ins[9:0]}; // RULE11
          slot = ins[10]; // RULE12
          done = 1'b1;
        end else if (is_loop) begin
          lidx = ins[8] ? rbbce_pkg::LOOP_B_IDX : rbbce_pkg::LOOP_A_IDX;
          jmp = ins[8] ? !r_reg.sr[rbbce_pkg::SR_ZB] : !r_reg.sr[rbbce_pkg::SR_ZA]; // RULE6
          jpc = r_reg.pc + rbbce_pkg::BR_BIAS + {{15{ins[6]}}, ins[6:0]};
          res = r_reg.gpr[lidx] - 16'h0001;
          r_next.gpr[lidx] = res; // RULE7
          if (ins[8]) begin
            r_next.sr[rbbce_pkg::SR_ZB] = (res == 16'h0000);
          end else begin
            r_next.sr[rbbce_pkg::SR_ZA] = (res == 16'h0000);
          end
          slot = 1'b1; // RULE8
          done = 1'b1;
        end else if (is_extc) begin
          jmp = I_EXT_COND[ins[8:7]]; // RULE13
          jpc = r_reg.pc + rbbce_pkg::BR_BIAS + {{15{ins[6]}}, ins[6:0]};
          slot = ins[10];
          done = 1'b1;
        end else begin
          done = 1'b1;
        end
      end
      rbbce_pkg::ST_IMM: begin
        res = r_reg.gpr[r_reg.instr[3:0]] & I_PROG_DATA;
        r_next.gpr[r_reg.instr[3:0]] = res; // RULE2
        r_next.sr[rbbce_pkg::SR_T] = (res == 16'h0000);
        if (r_reg.instr[3:0] == rbbce_pkg::LOOP_A_IDX) begin
          r_next.sr[rbbce_pkg::SR_ZA] = (res == 16'h0000); // RULE3
        end else if (r_reg.instr[3:0] == rbbce_pkg::LOOP_B_IDX) begin
          r_next.sr[rbbce_pkg::SR_ZB] = (res == 16'h0000); // RULE3
        end
        seq = r_reg.pc + rbbce_pkg::IMM_STEP; // RULE21
        done = 1'b1;
      end
      rbbce_pkg::ST_MRD: begin
        tmp = I_DATA_RDATA;
        r_next.sr[rbbce_pkg::SR_T] = !tmp[r_reg.instr[2:0]]; // RULE4
        unique case (r_reg.instr[4:3]) // RULE5
          rbbce_pkg::BIT_RESET_OP: tmp[r_reg.instr[2:0]] = 1'b0;
          rbbce_pkg::BIT_SET_OP: tmp[r_reg.instr[2:0]] = 1'b1;
          rbbce_pkg::BIT_FLIP_OP: tmp[r_reg.instr[2:0]] = !tmp[r_reg.instr[2:0]];
          rbbce_pkg::BIT_TEST_OP: tmp = I_DATA_RDATA;
          default: tmp = I_DATA_RDATA;
        endcase
        if (r_reg.instr[4:3] != rbbce_pkg::BIT_TEST_OP) begin
          r_next.data_wdata = tmp; // RULE5
          r_next.data_we = 1'b1;
          r_next.st = rbbce_pkg::ST_MWR;
        end else begin
          done = 1'b1;
        end
      end
      rbbce_pkg::ST_MWR: done = 1'b1;
      rbbce_pkg::ST_COP: begin
        if (!r_reg.cop_wr) begin
          r_next.gpr[{1'b0, r_reg.instr[2:0]}] = I_COPRO_RDATA; // RULE19
        end
        done = 1'b1;
      end
      rbbce_pkg::ST_BRK: done = 1'b1;
      default: r_next.st = rbbce_pkg::ST_IDLE;
    endcase
    if (done) begin
      if (jmp && !slot) begin
        npc = jpc; // RULE12
        r_next.pend = 1'b0;
      end else if (jmp) begin
        npc = seq;
        r_next.pend = 1'b1;
        r_next.pend_pc = jpc;
      end else if (r_reg.pend) begin
        npc = r_reg.pend_pc;
        r_next.pend = 1'b0;
      end else begin
        npc = seq;
      end
      r_next.pc = npc;
      r_next.prog_addr = npc;
      r_next.st = r_reg.run ? rbbce_pkg::ST_EXEC : rbbce_pkg::ST_IDLE;
    end

    // ***********************************************
    // Wishbone register access
    // ***********************************************
    if (I_WB_CYC && I_WB_STB && !r_reg.wb_ack) begin
      r_next.wb_ack = 1'b1;
      r_next.wb_dat = '0;
      if (wadr[5:4] == rbbce_pkg::GPR_PAGE) begin
        r_next.wb_dat = {16'h0000, r_reg.gpr[wadr[3:0]]};
      end else begin
        unique case ({wadr, 2'h0})
          rbbce_pkg::CTRL_OFS: r_next.wb_dat = {31'h00000000, r_reg.run};
          rbbce_pkg::SR_OFS: r_next.wb_dat = {24'h000000, r_reg.sr};
          rbbce_pkg::PC_OFS: r_next.wb_dat = {10'h000, r_reg.pc};
          rbbce_pkg::LINK_OFS: r_next.wb_dat = {10'h000, r_reg.link};
          rbbce_pkg::BASE_OFS: r_next.wb_dat = {10'h000, r_reg.base};
          rbbce_pkg::STATE_OFS: r_next.wb_dat = {24'h000000, r_reg.pend, r_reg.st};
          default: r_next.wb_dat = '0;
        endcase
      end
    end
    if (I_WB_CYC && I_WB_STB && I_WB_WE && r_reg.wb_ack) begin
      if (({wadr, 2'h0} == rbbce_pkg::CTRL_OFS) && I_WB_SEL[0]) begin
        r_next.run = I_WB_DAT[rbbce_pkg::CTRL_RUN];
      end else if (!r_reg.run && r_reg.st == rbbce_pkg::ST_IDLE) begin
        if (wadr[5:4] == rbbce_pkg::GPR_PAGE) begin
          wv = lane_merge({16'h0000, r_reg.gpr[wadr[3:0]]}, I_WB_DAT, I_WB_SEL);
          r_next.gpr[wadr[3:0]] = wv[15:0];
        end else if ({wadr, 2'h0} == rbbce_pkg::SR_OFS) begin
          wv = lane_merge({24'h000000, r_reg.sr}, I_WB_DAT, I_WB_SEL);
          r_next.sr = wv[7:0];
        end else if ({wadr, 2'h0} == rbbce_pkg::PC_OFS) begin
          wv = lane_merge({10'h000, r_reg.pc}, I_WB_DAT, I_WB_SEL);
          r_next.pc = wv[rbbce_pkg::PC_W-1:0];
          r_next.pend = 1'b0;
        end else if ({wadr, 2'h0} == rbbce_pkg::BASE_OFS) begin
          wv = lane_merge({10'h000, r_reg.base}, I_WB_DAT, I_WB_SEL);
          r_next.base = wv[rbbce_pkg::PC_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      r_reg <= '0;
      r_reg.st <= rbbce_pkg::ST_IDLE;
      r_reg.cop_stb_n <= 1'b1;
      r_reg.halt_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  assign O_WB_DAT = r_reg.wb_dat;
  assign O_WB_ACK = r_reg.wb_ack;
  assign O_PROG_ADDR = r_reg.prog_addr;
  assign O_DATA_ADDR = r_reg.data_addr;
  assign O_DATA_WDATA = r_reg.data_wdata;
  assign O_DATA_WE = r_reg.data_we;
  assign O_COPRO_REG_ADDR = r_reg.cop_addr;
  assign O_COPRO_STROBE_N = r_reg.cop_stb_n;
  assign O_COPRO_WRITE_DIR = r_reg.cop_wr;
  assign O_COPRO_WDATA = r_reg.cop_wdata;
  assign O_HALT_INDICATOR_N = r_reg.halt_n;

  // ***********************************************
  // Checks
  // ***********************************************
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);

  sequence s_bit_read;
    is_bit_modify ##1 (r_reg.st == rbbce_pkg::ST_MRD);
  endsequence

  a_and_imm_two: assert property ( // RULE1
    is_and_imm |=> (r_reg.st == rbbce_pkg::ST_IMM) && (O_PROG_ADDR == $past(r_reg.pc) + 22'h1)
  ) else $error("AND immediate did not fetch second word");

  a_and_zero_t: assert property ( // RULE2
    (r_reg.st == rbbce_pkg::ST_IMM) && ((r_reg.gpr[r_reg.instr[3:0]] & I_PROG_DATA) == 16'h0)
    |=> r_reg.sr[rbbce_pkg::SR_T]
  ) else $error("T not set on zero AND result");

  a_bit_addr: assert property ( // RULE4
    s_bit_read |-> O_DATA_ADDR == $past(r_reg.base) + {6'h00, $past(r_reg.gpr[1])}
  ) else $error("Bit op address wrong");

  a_bit_test_nowr: assert property ( // RULE5
    s_bit_read ##0 (r_reg.instr[4:3] == 2'h3) |=> !O_DATA_WE
  ) else $error("Bit test wrote memory");

  a_loop_dec_a: assert property ( // RULE7
    is_loop && !ins[8] |=> r_reg.gpr[6] == $past(r_reg.gpr[6]) - 16'h1
  ) else $error("Loop counter not decremented");

  a_halt_one_cycle: assert property ( // RULE14
    $fell(O_HALT_INDICATOR_N) |-> $stable(r_reg.pc) ##1 O_HALT_INDICATOR_N
  ) else $error("Halt indicator not one cycle");

  a_call_link: assert property ( // RULE16
    is_call |=> r_reg.link == $past(r_reg.pc) + 22'h4
  ) else $error("Call link value wrong");

  a_strobe_pulse: assert property ( // RULE18
    $fell(O_COPRO_STROBE_N) |-> (r_reg.st == rbbce_pkg::ST_COP) ##1 O_COPRO_STROBE_N
  ) else $error("Coprocessor strobe not one cycle");

  a_status_bit_clear_bit: assert property ( // RULE20
    is_status_bit_clear |=> !r_reg.sr[$past(ins[2:0])]
  ) else $error("Status bit not cleared");

  a_br_noslot: assert property ( // RULE12
    is_br && !ins[10] && (ins[12:11] == 2'h1) |=> r_reg.pc == $past(r_reg.pc) + 22'h2 +
      {{12{$past(ins[9])}}, $past(ins[9:0])}
  ) else $error("Undelayed branch did not jump");

endmodule

// *** bench/rbbce_copro_model.sv ***
module rbbce_copro_model (
  // Clock
  input wire logic i_clk,
  // Transfer request from the core
  input wire logic [4:0] i_addr,
  input wire logic i_strobe_n,
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  // Condition lines
  input wire logic [3:0] i_cond,
  output logic [3:0] o_ext_cond
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] regs [32];
  logic [15:0] last_q;

  initial begin
    foreach (regs[i]) regs[i] = 16'(16'h3c00 + i);
    last_q = 16'h0000;
  end

  // Address decoded only while strobed
  always @(posedge i_clk) begin
    if (i_strobe_n === 1'b0 && i_wr === 1'b1) regs[i_addr] <= i_wdata;
    if (i_strobe_n === 1'b0 && i_wr === 1'b0) last_q <= regs[i_addr];
  end

  // Bus scrambled when not driven
  assign o_rdata = (i_strobe_n === 1'b0 && i_wr === 1'b0) ? regs[i_addr] : ~last_q;
  assign o_ext_cond = i_cond;
endmodule

// *** bench/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************
  // Bench state
  // ****************
  logic clk, rst, cyc, stb, we, ack, dwe, cstb_n, cwr, halt_n;
  logic [7:0] adr, dwd, drd, sr;
  logic [3:0] cond, ec;
  logic [4:0] ca;
  logic [31:0] wd, rd, q;
  logic [21:0] pa, da;
  logic [15:0] pd, cwd, crd;
  logic [15:0] prog [64];
  logic [15:0] r [16];
  logic [15:0] cop [32];
  logic [7:0] dmem [256];
  logic [7:0] dm [256];
  int link, base, halts, n, n_errors, checked, seed;
  localparam logic [15:0] CODE [25] = '{
    16'h84f6, 16'h0003, 16'h9e01, 16'h9e0a, 16'h9e13, 16'h9e1c, 16'hc67a,
    16'he03e, 16'h9e99, 16'h9e83, 16'he072, 16'hd801, 16'h84f3, 16'h00ff,
    16'hc482, 16'he09b, 16'hd402, 16'h9e87, 16'h84f7, 16'h0000, 16'hb002,
    16'he035, 16'h0000, 16'h0000, 16'hcbfe};

  rbbce_exec rbbce_exec_inst (
    .I_MCLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wd), .O_WB_DAT(rd), .O_WB_ACK(ack),
    .O_PROG_ADDR(pa), .I_PROG_DATA(pd), .O_DATA_ADDR(da), .O_DATA_WDATA(dwd),
    .O_DATA_WE(dwe), .I_DATA_RDATA(drd), .O_COPRO_REG_ADDR(ca),
    .O_COPRO_STROBE_N(cstb_n), .O_COPRO_WRITE_DIR(cwr), .O_COPRO_WDATA(cwd),
    .I_COPRO_RDATA(crd), .I_EXT_COND(ec), .O_HALT_INDICATOR_N(halt_n));

  rbbce_copro_model rbbce_copro_model_inst (
    .i_clk(clk), .i_addr(ca), .i_strobe_n(cstb_n), .i_wr(cwr), .i_wdata(cwd),
    .o_rdata(crd), .i_cond(cond), .o_ext_cond(ec));

  assign pd = prog[pa[5:0]];
  assign drd = dmem[da[7:0]];
  always @(posedge clk) begin
    if (dwe === 1'b1) dmem[da[7:0]] <= dwd;
    if (halt_n === 1'b0) halts <= halts + 1;
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] o);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) n_errors++;
    o = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  function automatic int sx(input int v, input int b);
    return (v ^ (1 << (b - 1))) - (1 << (b - 1));
  endfunction

  // ****************
  // Instruction-level reference
  // ****************
  task automatic model();
    logic [15:0] w, res;
    logic [7:0] b;
    int pc, nx, tg, ptg, a, h, k;
    bit tk, sl, pend;
    pc = 0;
    pend = 0;
    ptg = 0;
    k = 0;
    while (pc != 24 && k < 500) begin
      w = prog[pc];
      nx = pc + 1;
      tk = 0;
      sl = 0;
      tg = 0;
      k++;
      if (w == 16'h9e99) begin
      end else if (w[15:4] == 12'h84f) begin
        res = r[w[3:0]] & prog[pc + 1];
        r[w[3:0]] = res;
        sr[7] = (res == 0);
        if (w[3:0] == 6) sr[4] = (res == 0);
        if (w[3:0] == 7) sr[5] = (res == 0);
        nx = pc + 2;
      end else if (w[15:5] == 11'h4f0) begin
        a = (base + r[1]) & 255;
        b = dm[a];
        sr[7] = ~b[w[2:0]];
        case (w[4:3])
          2'h0: b[w[2:0]] = 1'b0;
          2'h1: b[w[2:0]] = 1'b1;
          2'h2: b[w[2:0]] = ~b[w[2:0]];
          default: ;
        endcase
        dm[a] = b;
      end else if (w[15:3] == 13'h13d0) begin
        sr[w[2:0]] = 1'b0;
      end else if (w[15:9] == 7'h63) begin
        h = w[8];
        tk = !sr[4 + h];
        sl = 1;
        tg = pc + 2 + sx(w[6:0], 7);
        r[6 + h] = r[6 + h] - 1;
        sr[4 + h] = (r[6 + h] == 0);
      end else if (w[15:11] == 5'h18 && !w[9]) begin
        tk = cond[w[8:7]];
        sl = w[10];
        tg = pc + 2 + sx(w[6:0], 7);
      end else if (w[15:13] == 3'h6 && w[12:11] != 0) begin
        tk = w[12:11] == 1 || (w[12:11] == 3 && sr[7]) || (w[12:11] == 2 && !sr[7]);
        sl = w[10];
        tg = pc + 2 + sx(w[9:0], 10);
      end else if (w[15:12] == 4'hb) begin
        link = pc + 4;
        tk = 1;
        sl = 1;
        tg = pc + 2 + sx(w[11:0], 12);
      end else if (w[15:9] == 7'h70) begin
        if (w[3]) cop[w[8:4]] = r[w[2:0]];
        else r[w[2:0]] = cop[w[8:4]];
      end
      if (pend) nx = ptg;
      pend = tk && sl;
      ptg = tg;
      if (tk && !sl) nx = tg;
      pc = nx;
    end
  endtask

  initial begin
    seed = 67993;
    {rst, cyc, stb, we, adr, wd, cond, n_errors, checked, halts, link} = '0;
    rst = 1'b1;
    foreach (prog[i]) prog[i] = (i < 25) ? CODE[i] : 16'h0000;
    foreach (dmem[i]) dmem[i] = 8'h00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b1, rbbce_pkg::LINK_OFS, 32'hffffffff, q);
    wb(1'b1, 8'h30, 32'hffffffff, q);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'(i == 5 ? 8'h30 : 4 * i + (i == 4 ? 4 : 0)), 32'h0, q);
      check(q, (i == 4) ? 32'h1 : 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      cond <= 4'($random(seed));
      for (int i = 0; i < 16; i++) begin
        r[i] = 16'($random(seed));
        wb(1'b1, 8'(8'h40 + 4 * i), {16'h0, r[i]}, q);
      end
      sr = 8'($random(seed)) & 8'hcf;
      base = $random(seed) & 255;
      wb(1'b1, rbbce_pkg::SR_OFS, {24'h0, sr}, q);
      wb(1'b1, rbbce_pkg::BASE_OFS, 32'(base), q);
      wb(1'b1, rbbce_pkg::PC_OFS, 32'h0, q);
      foreach (dmem[i]) dmem[i] = 8'($random(seed));
      dm = dmem;
      cop = rbbce_copro_model_inst.regs;
      model();
      halts = 0;
      wb(1'b1, rbbce_pkg::CTRL_OFS, 32'h1, q);
      n = 0;
      while ((pa !== 22'd24 || n < 4) && n < 3000) begin
        @(posedge clk);
        n++;
      end
      if (n >= 3000) n_errors++;
      wb(1'b1, rbbce_pkg::CTRL_OFS, 32'h0, q);
      n = 0;
      do begin
        wb(1'b0, rbbce_pkg::STATE_OFS, 32'h0, q);
        n++;
      end while (q[6:0] !== 7'h01 && n < 50);
      if (q[6:0] !== 7'h01) n_errors++;
      for (int i = 0; i < 16; i++) begin
        wb(1'b0, 8'(8'h40 + 4 * i), 32'h0, q);
        check(q, {16'h0, r[i]});
      end
      wb(1'b0, rbbce_pkg::SR_OFS, 32'h0, q);
      check(q, {24'h0, sr});
      wb(1'b1, rbbce_pkg::LINK_OFS, 32'h0, q);
      wb(1'b0, rbbce_pkg::LINK_OFS, 32'h0, q);
      check(q, 32'(link));
      wb(1'b0, rbbce_pkg::PC_OFS, 32'h0, q);
      check(q, 32'd24);
      foreach (dm[i]) check({24'h0, dmem[i]}, {24'h0, dm[i]});
      foreach (cop[i]) check({16'h0, rbbce_copro_model_inst.regs[i]}, {16'h0, cop[i]});
      check(32'(halts), 32'h1);
    end
    summarize();
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule
